// ### core/adr_seq.sv
/*
 Two-wire target port with paged 8-bit registers, hardware and software
 reset, post-reset memory init lockout, PLL settling wait, output stage
 overcurrent latch and restart. Assumes the bus pins arrive asynchronous
 and resetn is already synchronous to clk.
*/
`timescale 1ns/1ns
`include "adr_map.svh"
module adr_seq #(
   parameter int INIT_CYC = `ADR_INIT_CYC,
   parameter int PLL_CYC = `ADR_PLL_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic headphone_left_overcurrent,
   input wire logic headphone_right_overcurrent,
   input wire logic spk_overcurrent,
   output logic init_busy,
   output logic pll_power_up,
   output logic clocks_ready,
   output logic dac_left_power_up,
   output logic dac_right_power_up,
   output logic headphone_left_output_enable,
   output logic headphone_right_output_enable,
   output logic speaker_output_enable
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_reg, sda_reg;
   // Second stage only is read; third stage gives edges
   always_ff @(posedge clk) begin
      if (!resetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_reg <= scl_sync_reg[1];
         sda_reg <= sda_sync_reg[1];
      end
   end
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   // 250 MHz oversamples even fast mode by far more than needed
   wire scl_rise = scl_s & ~scl_reg;
   wire scl_fall = ~scl_s & scl_reg;
   wire start_c = scl_s & scl_reg & sda_reg & ~sda_s;
   wire stop_c = scl_s & scl_reg & ~sda_reg & sda_s;

   // ----------------------------------------------------------------
   // Register file state
   // ----------------------------------------------------------------
   logic [7:0] page_reg, page_next;
   logic [7:0] p0_reg [0:127];
   logic [7:0] p1_reg [0:127];
   logic soft_rst;
   logic [7:0] wr_data;
   logic [6:0] wr_idx;
   logic wr_en;
   logic rst_all;
   assign rst_all = !resetn || soft_rst;

   // ----------------------------------------------------------------
   // Two-wire target engine
   // ----------------------------------------------------------------
   adr_pkg::adr_i2c_t st_reg, st_next;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] bit_reg, bit_next;
   logic [6:0] ptr_reg, ptr_next;
   logic rd_reg, rd_next;
   logic oe_reg, oe_next;
   logic [7:0] rdata;
   assign rdata = page_reg == 8'h00 ? p0_reg[ptr_reg] : (page_reg == 8'h01 ? p1_reg[ptr_reg] : 8'h00);
   // Bit engine; data shifted on rise, driven after fall
   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      bit_next = bit_reg;
      ptr_next = ptr_reg;
      rd_next = rd_reg;
      oe_next = oe_reg;
      wr_en = 1'b0;
      wr_idx = ptr_reg;
      wr_data = sh_reg;
      if (start_c) begin
         st_next = adr_pkg::ADR_ADDR;
         bit_next = 4'h0;
         oe_next = 1'b0;
      end else if (stop_c) begin
         st_next = adr_pkg::ADR_IDLE;
         oe_next = 1'b0;
      end else begin
         case (st_reg)
            adr_pkg::ADR_ADDR, adr_pkg::ADR_REG, adr_pkg::ADR_WDATA: begin
               if (scl_rise) begin
                  sh_next = {sh_reg[6:0], sda_s};
                  bit_next = bit_reg + 4'h1;
               end
               if (scl_fall && bit_reg == 4'h8) begin
                  bit_next = 4'h0;
                  if (st_reg == adr_pkg::ADR_ADDR) begin
                     if (sh_reg[7:1] == `ADR_TARGET_ADDR) begin
                        rd_next = sh_reg[0];
                        oe_next = 1'b1;
                        st_next = adr_pkg::ADR_ADDR_ACK;
                     end else begin
                        st_next = adr_pkg::ADR_SKIP;
                     end
                  end else if (st_reg == adr_pkg::ADR_REG) begin
                     ptr_next = sh_reg[6:0];
                     oe_next = 1'b1;
                     st_next = adr_pkg::ADR_REG_ACK;
                  end else begin
                     wr_en = 1'b1;
                     ptr_next = ptr_reg + 7'h1;
                     oe_next = 1'b1;
                     st_next = adr_pkg::ADR_WDATA_ACK;
                  end
               end
            end
            adr_pkg::ADR_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rd_reg) begin
                     sh_next = rdata;
                     oe_next = ~rdata[7];
                     st_next = adr_pkg::ADR_RDATA;
                  end else begin
                     oe_next = 1'b0;
                     st_next = adr_pkg::ADR_REG;
                  end
               end
            end
            adr_pkg::ADR_REG_ACK, adr_pkg::ADR_WDATA_ACK: begin
               if (scl_fall) begin
                  oe_next = 1'b0;
                  st_next = adr_pkg::ADR_WDATA;
               end
            end
            adr_pkg::ADR_RDATA: begin
               if (scl_rise) begin
                  bit_next = bit_reg + 4'h1;
               end
               if (scl_fall) begin
                  if (bit_reg == 4'h8) begin
                     bit_next = 4'h0;
                     oe_next = 1'b0;
                     ptr_next = ptr_reg + 7'h1;
                     st_next = adr_pkg::ADR_RDATA_ACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = ~sh_reg[6];
                  end
               end
            end
            adr_pkg::ADR_RDATA_ACK: begin
               // Host ack keeps reading, nack ends it
               if (scl_rise) begin
                  st_next = sda_s ? adr_pkg::ADR_SKIP : adr_pkg::ADR_ADDR_ACK;
               end
            end
            adr_pkg::ADR_IDLE, adr_pkg::ADR_SKIP: begin
               oe_next = 1'b0;
            end
            default: begin
               st_next = adr_pkg::ADR_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end
   // Engine registers; soft reset returns it to idle
   always_ff @(posedge clk) begin
      if (rst_all) begin
         st_reg <= adr_pkg::ADR_IDLE;
         sh_reg <= 8'h00;
         bit_reg <= 4'h0;
         ptr_reg <= 7'h00;
         rd_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         bit_reg <= bit_next;
         ptr_reg <= ptr_next;
         rd_reg <= rd_next;
         oe_reg <= oe_next;
      end
   end
   // Open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;

   // ----------------------------------------------------------------
   // Paged registers
   // ----------------------------------------------------------------
   assign page_next = (wr_en && wr_idx == `ADR_REG_PAGE_SEL) ? wr_data : page_reg;
   assign soft_rst = wr_en && page_reg == 8'h00 && wr_idx == `ADR_REG_SW_RESET
      && wr_data[`ADR_SW_RESET_BIT];
   // Storage is never touched by power control, only by writes and resets
   always_ff @(posedge clk) begin
      if (rst_all) begin
         page_reg <= `ADR_RESET_VAL;
         for (int i = 0; i < 128; i++) begin
            p0_reg[i] <= `ADR_RESET_VAL;
            p1_reg[i] <= `ADR_RESET_VAL;
         end
      end else begin
         page_reg <= page_next;
         if (wr_en && wr_idx != `ADR_REG_PAGE_SEL && page_reg == 8'h00) begin
            p0_reg[wr_idx] <= wr_data;
         end
         if (wr_en && wr_idx != `ADR_REG_PAGE_SEL && page_reg == 8'h01) begin
            // Stage reset bits are strobes and never stored
            if (wr_idx == `ADR_REG_HP_STAGE) begin
               p1_reg[wr_idx] <= wr_data & 8'h3f;
            end else if (wr_idx == `ADR_REG_SPK_STAGE) begin
               p1_reg[wr_idx] <= wr_data & 8'h7f;
            end else begin
               p1_reg[wr_idx] <= wr_data;
            end
         end
         p0_reg[`ADR_REG_SW_RESET] <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Init lockout and PLL settling
   // ----------------------------------------------------------------
   logic [31:0] init_cnt_reg, init_cnt_next;
   logic [31:0] pll_cnt_reg, pll_cnt_next;
   logic pll_en;
   assign pll_en = p0_reg[`ADR_REG_PLL_PWR][`ADR_PLL_PWR_BIT];
   // Lockout counts from reset release; PLL wait restarts on power down
   always_comb begin
      init_cnt_next = init_cnt_reg;
      if (init_cnt_reg != 32'h0) begin
         init_cnt_next = init_cnt_reg - 32'h1;
      end
      pll_cnt_next = pll_cnt_reg;
      if (!pll_en) begin
         pll_cnt_next = PLL_CYC[31:0];
      end else if (pll_cnt_reg != 32'h0) begin
         pll_cnt_next = pll_cnt_reg - 32'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst_all) begin
         init_cnt_reg <= INIT_CYC[31:0];
         pll_cnt_reg <= PLL_CYC[31:0];
      end else begin
         init_cnt_reg <= init_cnt_next;
         pll_cnt_reg <= pll_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Output stage latch-off and power outputs
   // ----------------------------------------------------------------
   logic left_trip_reg, right_trip_reg, spk_trip_reg;
   logic left_trip_next, right_trip_next, spk_trip_next;
   logic [7:0] hp_w, spk_w;
   logic p1_wr;
   assign p1_wr = wr_en && page_reg == 8'h01;
   assign hp_w = (p1_wr && wr_idx == `ADR_REG_HP_STAGE) ? wr_data : 8'h00;
   assign spk_w = (p1_wr && wr_idx == `ADR_REG_SPK_STAGE) ? wr_data : 8'h00;
   // New overcurrent wins over a restart in the same cycle
   always_comb begin
      left_trip_next = headphone_left_overcurrent | (left_trip_reg & ~hp_w[`ADR_LEFT_RST_BIT]);
      right_trip_next = headphone_right_overcurrent | (right_trip_reg & ~hp_w[`ADR_RIGHT_RST_BIT]);
      spk_trip_next = spk_overcurrent | (spk_trip_reg & ~spk_w[`ADR_SPK_RST_BIT]);
   end
   always_ff @(posedge clk) begin
      if (rst_all) begin
         left_trip_reg <= 1'b0;
         right_trip_reg <= 1'b0;
         spk_trip_reg <= 1'b0;
         init_busy <= 1'b1;
         pll_power_up <= 1'b0;
         clocks_ready <= 1'b0;
         dac_left_power_up <= 1'b0;
         dac_right_power_up <= 1'b0;
         headphone_left_output_enable <= 1'b0;
         headphone_right_output_enable <= 1'b0;
         speaker_output_enable <= 1'b0;
      end else begin
         left_trip_reg <= left_trip_next;
         right_trip_reg <= right_trip_next;
         spk_trip_reg <= spk_trip_next;
         init_busy <= init_cnt_next != 32'h0;
         pll_power_up <= pll_en;
         clocks_ready <= pll_en && pll_cnt_next == 32'h0;
         dac_left_power_up <= p0_reg[`ADR_REG_DAC_PWR][`ADR_DAC_L_PWR_BIT];
         dac_right_power_up <= p0_reg[`ADR_REG_DAC_PWR][`ADR_DAC_R_PWR_BIT];
         headphone_left_output_enable <= p1_reg[`ADR_REG_HP_PWR][`ADR_LEFT_PWR_BIT] & ~left_trip_next;
         headphone_right_output_enable <= p1_reg[`ADR_REG_HP_PWR][`ADR_RIGHT_PWR_BIT] & ~right_trip_next;
         speaker_output_enable <= p1_reg[`ADR_REG_SPK_PWR][`ADR_SPK_PWR_BIT] & ~spk_trip_next;
      end
   end
endmodule : adr_seq

// ### core/adr_map.svh
/*
 Register map, field positions, reset values and timing counts of the
 audio converter reset, init and power sequencer. Assumes a 250 MHz clock.
*/
`ifndef ADR_MAP_SVH
`define ADR_MAP_SVH
`define ADR_TARGET_ADDR 7'h18
`define ADR_REG_PAGE_SEL 7'h00
`define ADR_REG_SW_RESET 7'h01
`define ADR_SW_RESET_BIT 0
`define ADR_REG_HP_STAGE 7'h1f
`define ADR_LEFT_RST_BIT 7
`define ADR_RIGHT_RST_BIT 6
`define ADR_REG_SPK_STAGE 7'h20
`define ADR_SPK_RST_BIT 7
`define ADR_REG_PLL_PWR 7'h05
`define ADR_PLL_PWR_BIT 7
`define ADR_REG_DAC_PWR 7'h3f
`define ADR_DAC_L_PWR_BIT 7
`define ADR_DAC_R_PWR_BIT 6
`define ADR_REG_HP_PWR 7'h1f
`define ADR_REG_SPK_PWR 7'h20
`define ADR_LEFT_PWR_BIT 5
`define ADR_RIGHT_PWR_BIT 4
`define ADR_SPK_PWR_BIT 6
`define ADR_RESET_VAL 8'h00
`define ADR_CLK_MHZ 250
`define ADR_INIT_US 1000
`define ADR_INIT_CYC (`ADR_INIT_US * `ADR_CLK_MHZ)
`define ADR_PLL_MS 10
`define ADR_PLL_CYC (`ADR_PLL_MS * 1000 * `ADR_CLK_MHZ)
`endif

// ### core/adr_pkg.sv
/*
 Types of the reset, init and power sequencer. Assumes adr_map.svh.
*/
package adr_pkg;
   typedef enum logic [3:0] {ADR_IDLE, ADR_ADDR, ADR_ADDR_ACK, ADR_REG, ADR_REG_ACK,
      ADR_WDATA, ADR_WDATA_ACK, ADR_RDATA, ADR_RDATA_ACK, ADR_SKIP} adr_i2c_t;
endpackage : adr_pkg

// ### sim/adr_seq_properties.sv
/*
 Port-level checks of adr_seq.
 Assumes it is bound into adr_seq and sees only its ports.
*/
`timescale 1ns/1ns
module adr_seq_properties #(
   parameter int INIT_CYC = 250000,
   parameter int PLL_CYC = 2500000
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic headphone_left_overcurrent,
   input wire logic headphone_right_overcurrent,
   input wire logic spk_overcurrent,
   input wire logic init_busy,
   input wire logic pll_power_up,
   input wire logic clocks_ready,
   input wire logic dac_left_power_up,
   input wire logic dac_right_power_up,
   input wire logic headphone_left_output_enable,
   input wire logic headphone_right_output_enable,
   input wire logic speaker_output_enable
);
   logic [5:0] pwr;
   int pll_cnt_reg, pll_cnt_next, busy_cnt_reg, busy_cnt_next;
   // All block power outputs in one word
   assign pwr = {pll_power_up, dac_left_power_up, dac_right_power_up, headphone_left_output_enable,
      headphone_right_output_enable, speaker_output_enable};
   // Run lengths; no saturation, a run never nears the int range
   always_comb begin
      pll_cnt_next = pll_power_up ? pll_cnt_reg + 1 : 0;
      busy_cnt_next = init_busy ? busy_cnt_reg + 1 : 0;
   end
   always_ff @(posedge clk) begin
      pll_cnt_reg <= resetn ? pll_cnt_next : 0;
      busy_cnt_reg <= resetn ? busy_cnt_next : 0;
   end
   default clocking cb @(posedge clk); endclocking
   property p_rst; disable iff (1'b0) !resetn |=> init_busy && pwr == 6'h00 && !clocks_ready && !sda_oe; endproperty
   a_rst: assert property (p_rst) else $error("outputs active in reset");
   property p_soft; disable iff (!resetn) $rose(init_busy) |-> pwr == 6'h00 && !clocks_ready; endproperty
   a_soft: assert property (p_soft) else $error("block powered at soft reset");
   property p_init; disable iff (!resetn) busy_cnt_reg <= INIT_CYC + 3; endproperty
   a_init: assert property (p_init) else $error("init phase too long");
   property p_pll_early; disable iff (!resetn) $rose(clocks_ready) |-> pll_cnt_reg >= PLL_CYC - 3; endproperty
   a_pll_early: assert property (p_pll_early) else $error("clocks released early");
   // Only while the PLL stays on; power-down drops both outputs together
   property p_pll_late; disable iff (!resetn) pll_power_up && pll_cnt_reg >= PLL_CYC + 3 |-> clocks_ready; endproperty
   a_pll_late: assert property (p_pll_late) else $error("clocks released late");
   property p_hp_left; disable iff (!resetn)
      headphone_left_overcurrent |-> ##[1:2] !headphone_left_output_enable; endproperty
   a_hp_left: assert property (p_hp_left) else $error("left stage not tripped");
   property p_hp_right; disable iff (!resetn)
      headphone_right_overcurrent |-> ##[1:2] !headphone_right_output_enable; endproperty
   a_hp_right: assert property (p_hp_right) else $error("right stage not tripped");
   property p_spk; disable iff (!resetn) spk_overcurrent |-> ##[1:2] !speaker_output_enable; endproperty
   a_spk: assert property (p_spk) else $error("speaker stage not tripped");
   property p_oe; disable iff (!resetn) $rose(sda_oe) |-> !scl_in; endproperty
   a_oe: assert property (p_oe) else $error("data driven while clock high");
endmodule : adr_seq_properties
bind adr_seq adr_seq_properties #(.INIT_CYC(INIT_CYC), .PLL_CYC(PLL_CYC)) u_props (.clk(clk), .resetn(resetn),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .headphone_left_overcurrent(headphone_left_overcurrent),
   .headphone_right_overcurrent(headphone_right_overcurrent),
   .spk_overcurrent(spk_overcurrent), .init_busy(init_busy),
   .pll_power_up(pll_power_up), .clocks_ready(clocks_ready), .dac_left_power_up(dac_left_power_up),
   .dac_right_power_up(dac_right_power_up), .headphone_left_output_enable(headphone_left_output_enable),
   .headphone_right_output_enable(headphone_right_output_enable), .speaker_output_enable(speaker_output_enable));

// ### sim/adr_host.sv
/*
 Two-wire bus master model standing for the host processor.
 Assumes an open-drain data wire with pull-up, resolved by the bench.
*/
`timescale 1ns/1ns
module adr_host (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   int q = 8; // Quarter bit in clocks; 156 gives fast-mode rate
   logic [6:0] tgt = 7'h18;
   logic ack_ok;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // All changes land just after a falling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      tick(q);
      scl = 1'b1;
      tick(2 * q);
      r = sda;
      scl = 1'b0;
      tick(q);
   endtask : bit_io
   task automatic start();
      sda_low = 1'b0;
      tick(q);
      scl = 1'b1;
      tick(q);
      sda_low = 1'b1;
      tick(q);
      scl = 1'b0;
      tick(q);
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      tick(q);
      scl = 1'b1;
      tick(q);
      sda_low = 1'b0;
      tick(q);
   endtask : stop
   task automatic put(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack_ok = ack_ok & !r;
   endtask : put
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask : get
   // Writes the low n bytes of d, the higher byte first
   task automatic wr(input logic [6:0] idx, input logic [15:0] d, input int n);
      ack_ok = 1'b1;
      start();
      put({tgt, 1'b0});
      put({1'b0, idx});
      for (int i = n - 1; i >= 0; i--) put(d[8 * i +: 8]);
      stop();
   endtask : wr
   task automatic rd(input logic [6:0] idx, input int n, output logic [15:0] d);
      logic [7:0] b;
      d = 16'h0000;
      ack_ok = 1'b1;
      start();
      put({tgt, 1'b0});
      put({1'b0, idx});
      start();
      put({tgt, 1'b1});
      for (int i = n - 1; i >= 0; i--) begin
         get(i == 0, b);
         d[8 * i +: 8] = b;
      end
      stop();
   endtask : rd
endmodule : adr_host

// ### sim/testbench.sv
/*
 Self-checking bench for adr_seq through the host model.
 Assumes adr_host and the bound checker are compiled first.
*/
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] oc = 3'h0;
   logic sda_line, scl, sda_low, sda_oe, sda_out;
   wire [7:0] outs;
   logic [15:0] v;
   int err_total = 0;
   int cmp_count = 0;
   logic [6:0] st_idx [3] = '{7'h1f, 7'h1f, 7'h20};
   logic [7:0] st_dat [3] = '{8'hb0, 8'h70, 8'hc0};
   logic [7:0] st_bck [3] = '{8'h30, 8'h30, 8'h40};
   always #2 clk = ~clk;
   // Open-drain data wire with pull-up
   assign sda_line = !sda_low && (sda_oe ? sda_out : 1'b1);
   adr_host h (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(sda_low));
   adr_seq #(.INIT_CYC(50), .PLL_CYC(100)) dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .headphone_left_overcurrent(oc[2]),
      .headphone_right_overcurrent(oc[1]), .spk_overcurrent(oc[0]),
      .init_busy(outs[7]), .pll_power_up(outs[6]), .clocks_ready(outs[5]), .dac_left_power_up(outs[4]),
      .dac_right_power_up(outs[3]), .headphone_left_output_enable(outs[2]),
      .headphone_right_output_enable(outs[1]), .speaker_output_enable(outs[0]));
   task automatic summarize();
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask : chk
   // Bounded wait; a hang ends the run
   task automatic wait_outs(input logic [7:0] m, input logic [7:0] val, input int lim);
      int n = 0;
      while ((outs & m) !== val && n < lim) begin
         @(negedge clk);
         n++;
      end
      if ((outs & m) !== val) begin
         chk("wait", {8'h00, val}, {8'h00, outs & m});
         summarize();
      end
   endtask : wait_outs
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      chk("out_rst", 16'h80, outs);
      wait_outs(8'h80, 8'h00, 60);
      h.tgt = 7'h19;
      h.wr(7'h3f, 16'hc0, 1);
      chk("nack", 16'h0, h.ack_ok);
      chk("out_nack", 16'h0, outs);
      h.tgt = 7'h18;
      h.wr(7'h3f, 16'hc0, 1);
      chk("ack", 16'h1, h.ack_ok);
      h.rd(7'h3f, 1, v);
      chk("dac_rd", 16'hc0, v);
      h.wr(7'h1f, 16'h30, 1);
      chk("out_pg0", 16'h18, outs);
      h.wr(7'h00, 16'h01, 1);
      h.wr(7'h1f, 16'h3040, 2);
      chk("out_on", 16'h1f, outs);
      h.rd(7'h1f, 2, v);
      chk("stage_rd", 16'h3040, v);
      // Trip each stage, restart it, registers must survive
      for (int i = 0; i < 3; i++) begin
         oc = 3'h4 >> i;
         @(negedge clk);
         oc = 3'h0;
         repeat (3) @(negedge clk);
         chk("out_trip", {8'h00, 8'h1f & ~(8'h04 >> i)}, outs);
         h.wr(st_idx[i], {8'h00, st_dat[i]}, 1);
         chk("out_restart", 16'h1f, outs);
         h.rd(st_idx[i], 1, v);
         chk("kept", {8'h00, st_bck[i]}, v);
      end
      h.wr(7'h00, 16'h00, 1);
      h.wr(7'h05, 16'h80, 1);
      wait_outs(8'h20, 8'h20, 130);
      chk("out_pll", 16'h7f, outs);
      h.wr(7'h3f, 16'h00, 1);
      h.rd(7'h05, 1, v);
      chk("pll_kept", 16'h80, v);
      chk("out_dac_off", 16'h67, outs);
      h.q = 156;
      h.wr(7'h3f, 16'h40, 1);
      h.q = 8;
      chk("out_fast", 16'h6f, outs);
      h.wr(7'h01, 16'h01, 1);
      chk("out_soft", 16'h00, outs & 8'h7f);
      wait_outs(8'h80, 8'h00, 60);
      h.rd(7'h00, 2, v);
      chk("soft_rd", 16'h0000, v);
      // Unknown page: writes dropped, reads give zero
      h.wr(7'h00, 16'h02, 1);
      h.wr(7'h3f, 16'hff, 1);
      chk("out_pg2", 16'h00, outs);
      h.rd(7'h3f, 1, v);
      chk("pg2_rd", 16'h00, v);
      h.wr(7'h00, 16'h00, 1);
      h.wr(7'h3f, 16'hc0, 1);
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      chk("out_hw", 16'h80, outs);
      resetn = 1'b1;
      wait_outs(8'h80, 8'h00, 60);
      h.rd(7'h3f, 1, v);
      chk("hw_rd", 16'h00, v);
      summarize();
   end
endmodule : testbench
